// ==== design/wscl_device.sv ====
// Behaviour
// - wiper outputs follow volatile registers, unlimited rewrites
// - power-on loads wipers from nonvolatile copies
// - store lasts 25 ms, device busy
// - restore enters read state until no-operation
// - host polls acknowledge after store, reset
// - step up/down, one or all channels
// - single-channel shift left doubles, right halves
// - all-channel shifts act on every channel
// - shift left of zero gives one
// - shift left from midscale gives full scale
// - shift right drops LSB, zero enters top
// - undriven write-protect pin means protected
// - reset pin needs external tie high
// - memory pins set memory bus address
// - slave pins set device bus address
// - user bytes share memory data format
// - four-bit command field equals command number
// - channels zero, one hold nine bits
// - channel two holds seven bits
`default_nettype none
module wscl_device #(
   parameter int unsigned STORE_CYCLES = wscl_pkg::STORE_CYCLES
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // two-wire link
   wscl_link_if.device link,
   // pins
   input wire logic wp,
   input wire logic hw_reset_n,
   input wire logic slave_address_pin_high,
   input wire logic slave_address_pin_low,
   input wire logic memory_address_pin_high,
   input wire logic memory_address_pin_low,
   // wiper and state outputs
   output logic [8:0] wiper0,
   output logic [8:0] wiper1,
   output logic [6:0] wiper2,
   output logic busy,
   output logic nv_read_state
);
   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_INST, S_DATA, S_IGNORE} wscl_dev_state_t;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam logic [7:0] PIN_RST = 8'hC2; // scl, sda, reset pin idle high
   logic [7:0] pin_meta;
   logic [7:0] pin_sync;
   logic [1:0] line_q;
   wire logic [7:0] pin_raw = {link.scl, link.sda, memory_address_pin_high, memory_address_pin_low,
                               slave_address_pin_high, slave_address_pin_low, hw_reset_n, wp};

   // two flops on every outside input
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= PIN_RST;
         pin_sync <= PIN_RST;
         line_q <= 2'h3;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         line_q <= pin_sync[7:6];
      end
   end

   wire logic scl_s = pin_sync[7];
   wire logic sda_s = pin_sync[6];
   wire logic [1:0] mem_pins = pin_sync[5:4];
   wire logic [1:0] slave_pins = pin_sync[3:2];
   wire logic reset_pin_low = ~pin_sync[1];
   wire logic wp_ok = pin_sync[0];
   wire logic scl_rise = scl_s & ~line_q[1];
   wire logic scl_fall = ~scl_s & line_q[1];
   wire logic start_det = scl_s & line_q[1] & line_q[0] & ~sda_s;
   wire logic stop_det = scl_s & line_q[1] & ~line_q[0] & sda_s;

   // ----------------------------------------------------------------
   // bit engine
   // ----------------------------------------------------------------
   wscl_dev_state_t st;
   wscl_dev_state_t next_st;
   logic [3:0] bitn;
   logic ack_phase;
   logic [7:0] shreg;
   logic drive;
   logic nvsel;
   logic [4:0] ptr;
   logic [31:0] busy_cnt;
   logic por_load;
   logic [7:0] nv_mem [wscl_pkg::NV_BYTES];
   logic [8:0] pos [3];

   wire logic ack_evt = scl_fall & (bitn == 4'h8) & ~ack_phase;
   wire logic wiper_hit = (shreg[7:3] == wscl_pkg::WIPER_PREFIX) & (shreg[2:1] == slave_pins);
   wire logic mem_hit = (shreg[7:3] == wscl_pkg::MEM_PREFIX) & (shreg[2:1] == mem_pins);
   wire logic addr_ok = ~shreg[0] & ~busy & (wiper_hit | mem_hit);
   wire logic want_ack = (st == S_ADDR) ? addr_ok : (st != S_IDLE);

   // framing, shifting and acknowledge drive
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= S_IDLE;
         bitn <= 4'h0;
         ack_phase <= 1'b0;
         shreg <= 8'h00;
         drive <= 1'b0;
      end else if (start_det) begin
         st <= S_ADDR;
         bitn <= 4'h0;
         ack_phase <= 1'b0;
         drive <= 1'b0;
      end else if (stop_det) begin
         st <= S_IDLE;
         drive <= 1'b0;
      end else if (scl_rise && bitn != 4'h8 && st != S_IDLE) begin
         shreg <= {shreg[6:0], sda_s};
         bitn <= bitn + 4'h1;
      end else if (ack_evt) begin
         drive <= want_ack;
         ack_phase <= 1'b1;
         st <= next_st;
      end else if (scl_fall && ack_phase) begin
         drive <= 1'b0;
         ack_phase <= 1'b0;
         bitn <= 4'h0;
      end
   end

   // state after each byte
   always_comb begin
      next_st = st;
      unique case (st)
         S_IDLE: next_st = S_IDLE;
         S_ADDR: next_st = !addr_ok ? S_IDLE : (wiper_hit ? S_INST : S_IGNORE);
         S_INST: next_st = shreg[wscl_pkg::CMD_FLAG_BIT] ? S_IGNORE : S_DATA;
         S_DATA: next_st = S_DATA;
         S_IGNORE: next_st = S_IGNORE;
      endcase
   end

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire logic cmd_go = ack_evt & (st == S_INST) & shreg[wscl_pkg::CMD_FLAG_BIT];
   wire logic [3:0] cmd = shreg[wscl_pkg::CMD_MSB:wscl_pkg::CMD_LSB];
   wire logic [1:0] cmd_ch = shreg[wscl_pkg::CH_MSB:0];
   wire logic inst_wr = ack_evt & (st == S_INST) & ~shreg[wscl_pkg::CMD_FLAG_BIT];
   wire logic data_ack = ack_evt & (st == S_DATA);
   wire logic reg_wr = data_ack & ~nvsel;
   wire logic nv_wr = data_ack & nvsel & ~ptr[4] & wp_ok & ~busy;
   wire logic store_go = cmd_go & (cmd == wscl_pkg::CMD_STORE) & (cmd_ch != 2'h3) & wp_ok & ~busy;
   wire logic restore_all = por_load | reset_pin_low | (cmd_go & (cmd == wscl_pkg::CMD_RESET_ALL));
   wire logic restore_one = cmd_go & (cmd == wscl_pkg::CMD_RESTORE);
   wire logic op_all = (cmd == wscl_pkg::CMD_SHR_ALL) | (cmd == wscl_pkg::CMD_DN_ALL) |
                       (cmd == wscl_pkg::CMD_SHL_ALL) | (cmd == wscl_pkg::CMD_UP_ALL);
   wire logic op_up = (cmd == wscl_pkg::CMD_UP) | (cmd == wscl_pkg::CMD_UP_ALL);
   wire logic op_dn = (cmd == wscl_pkg::CMD_DN) | (cmd == wscl_pkg::CMD_DN_ALL);
   wire logic op_shl = (cmd == wscl_pkg::CMD_SHL) | (cmd == wscl_pkg::CMD_SHL_ALL);
   wire logic op_shr = (cmd == wscl_pkg::CMD_SHR) | (cmd == wscl_pkg::CMD_SHR_ALL);
   wire logic [7:0] store_lo = pos[cmd_ch][7:0];
   wire logic [7:0] store_hi = {7'h00, pos[cmd_ch][8]};

   // register pointer, power-on load, nonvolatile read state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         nvsel <= 1'b0;
         ptr <= 5'h00;
         por_load <= 1'b1;
         nv_read_state <= 1'b0;
      end else begin
         por_load <= 1'b0;
         if (inst_wr) begin
            nvsel <= shreg[wscl_pkg::NV_SEL_BIT];
            ptr <= shreg[wscl_pkg::ADDR_MSB:0];
         end else if (data_ack) begin
            ptr <= ptr + 5'h01;
         end
         if (restore_one)
            nv_read_state <= 1'b1;
         else if (cmd_go && cmd == wscl_pkg::CMD_NO_OPERATION)
            nv_read_state <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // nonvolatile store and busy timer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < wscl_pkg::NV_BYTES; i++)
            nv_mem[i] <= wscl_pkg::NV_RESET_VAL[i];
      end else if (nv_wr) begin
         nv_mem[ptr[3:0]] <= shreg;
      end else if (store_go) begin
         nv_mem[{1'b0, cmd_ch, 1'b0}] <= store_lo;
         if (cmd_ch != 2'h2)
            nv_mem[{1'b0, cmd_ch, 1'b1}] <= store_hi;
      end
   end

   // busy count for the store time
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_cnt <= 32'h0000_0000;
         busy <= 1'b0;
      end else begin
         if (store_go || nv_wr)
            busy_cnt <= STORE_CYCLES - 1;
         else if (busy_cnt != 32'h0000_0000)
            busy_cnt <= busy_cnt - 32'h0000_0001;
         busy <= store_go | nv_wr | (busy_cnt != 32'h0000_0000);
      end
   end

   // ----------------------------------------------------------------
   // wiper channels
   // ----------------------------------------------------------------
   for (genvar c = 0; c < 3; c++) begin : g_ch
      localparam logic [8:0] FS = (c == 2) ? wscl_pkg::FS7 : wscl_pkg::FS9;
      localparam logic [8:0] MID = (c == 2) ? wscl_pkg::MID7 : wscl_pkg::MID9;
      localparam logic [3:0] LO = 4'(2 * c);
      localparam logic [3:0] HI = 4'(2 * c + 1);
      wire logic mine = cmd_go & (op_all | (cmd_ch == 2'(c)));
      wire logic [8:0] p = pos[c];
      wire logic [8:0] up1 = (p == FS) ? FS : p + 9'h001;
      wire logic [8:0] dn1 = (p == 9'h000) ? 9'h000 : p - 9'h001;
      wire logic [8:0] shl = (p == 9'h000) ? 9'h001 : ((p >= MID) ? FS : {p[7:0], 1'b0});
      wire logic [8:0] shr = {1'b0, p[8:1]};
      wire logic [8:0] nv_val = (c == 2) ? {2'h0, nv_mem[LO][6:0]} : {nv_mem[HI][0], nv_mem[LO]};
      wire logic [8:0] lo_val = (c == 2) ? {2'h0, shreg[6:0]} : {p[8], shreg};

      // one channel's position register
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n)
            pos[c] <= 9'h000;
         else if (restore_all || (restore_one && cmd_ch == 2'(c)))
            pos[c] <= nv_val;
         else if (mine && op_up)
            pos[c] <= up1;
         else if (mine && op_dn)
            pos[c] <= dn1;
         else if (mine && op_shl)
            pos[c] <= shl;
         else if (mine && op_shr)
            pos[c] <= shr;
         else if (reg_wr && ptr == {1'b0, LO})
            pos[c] <= lo_val;
         else if (reg_wr && c != 2 && ptr == {1'b0, HI})
            pos[c] <= {shreg[0], p[7:0]};
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign wiper0 = pos[0];
   assign wiper1 = pos[1];
   assign wiper2 = pos[2][6:0];
   assign link.dev_sda_oe = drive;
   assign link.dev_sda_o = 1'b0; // open drain, only pulls low
endmodule : wscl_device
`default_nettype wire

// ==== design/wscl_host.sv ====
`default_nettype none
module wscl_host (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // two-wire link
   wscl_link_if.host link
);
   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} wscl_host_state_t;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   wscl_host_state_t st;
   logic [7:0] inst;
   logic [7:0] data;
   logic has_data;
   logic [1:0] pins;
   logic poll_req;
   logic polling;
   logic nack;
   logic nv_pend;
   logic sda_meta;
   logic sda_sync;
   logic [3:0] qcnt;
   logic [1:0] ph;
   logic [3:0] bitn;
   logic [1:0] bytei;
   logic [1:0] last;
   logic acked;
   logic scl;
   logic sda_oe;

   wire logic active = (st != H_IDLE);
   wire logic frame_sel = (avs_address == wscl_pkg::FRAME_OFFSET);
   wire logic status_sel = (avs_address == wscl_pkg::STATUS_OFFSET);
   wire logic accept = (avs_read | avs_write) & avs_waitrequest & ~(avs_write & frame_sel & active);
   wire logic launch = avs_write & ~avs_waitrequest & frame_sel;
   wire logic [31:0] status_word = {29'h0, nv_pend, nack, active};
   wire logic [31:0] rd_word = status_sel ? status_word : 32'h0000_0000;

   // one-cycle answer, frame writes held off while a frame runs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~accept;
         if (accept)
            avs_readdata <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // link engine
   // ----------------------------------------------------------------
   wire logic tick = (qcnt == 4'h0);
   wire logic [7:0] addr_byte = {wscl_pkg::WIPER_PREFIX, pins, 1'b0};
   wire logic [7:0] cur_byte = (bytei == 2'h0) ? addr_byte : ((bytei == 2'h1) ? inst : data);
   wire logic cur_bit = cur_byte[3'h7 - bitn[2:0]];
   wire logic ack_bit = (bitn == 4'h8);
   wire logic sent_cmd = inst[wscl_pkg::CMD_FLAG_BIT];
   wire logic [3:0] sent_code = inst[wscl_pkg::CMD_MSB:wscl_pkg::CMD_LSB];

   // data line sampled through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
      end
   end

   // frame sequencer on quarter-period ticks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st <= H_IDLE;
         {inst, data} <= 16'h0000;
         {has_data, pins, poll_req, polling, nack, nv_pend, acked} <= 8'h00;
         {qcnt, ph, bitn, bytei, last} <= 14'h0000;
         scl <= 1'b1;
         sda_oe <= 1'b0;
      end else if (launch) begin
         inst <= avs_writedata[7:0];
         data <= avs_writedata[wscl_pkg::FR_DATA_LSB +: 8];
         has_data <= avs_writedata[wscl_pkg::FR_HAS_DATA_BIT];
         pins <= avs_writedata[wscl_pkg::FR_PINS_LSB +: 2];
         poll_req <= avs_writedata[wscl_pkg::FR_POLL_BIT];
         last <= avs_writedata[wscl_pkg::FR_HAS_DATA_BIT] ? 2'h2 : 2'h1;
         st <= H_START;
         {qcnt, ph} <= 6'h00;
      end else if (active) begin
         qcnt <= tick ? wscl_pkg::SCL_QUARTER : qcnt - 4'h1;
         if (tick) begin
            ph <= ph + 2'h1;
            unique case (st)
               H_START: begin
                  if (ph == 2'h0) {scl, sda_oe} <= 2'b10;
                  if (ph == 2'h1) sda_oe <= 1'b1;
                  if (ph == 2'h2) scl <= 1'b0;
                  if (ph == 2'h3) {st, bitn, bytei} <= {H_BIT, 6'h00};
               end
               H_BIT: begin
                  if (ph == 2'h0) sda_oe <= ack_bit ? 1'b0 : ~cur_bit;
                  if (ph == 2'h1) scl <= 1'b1;
                  if (ph == 2'h2 && ack_bit) acked <= ~sda_sync;
                  if (ph == 2'h3) begin
                     scl <= 1'b0;
                     if (!ack_bit)
                        bitn <= bitn + 4'h1;
                     else if (!acked || bytei == last)
                        st <= H_STOP;
                     else
                        {bytei, bitn} <= {bytei + 2'h1, 4'h0};
                  end
               end
               H_STOP: begin
                  if (ph == 2'h0) sda_oe <= 1'b1;
                  if (ph == 2'h1) scl <= 1'b1;
                  if (ph == 2'h2) sda_oe <= 1'b0;
                  if (ph == 2'h3) begin
                     nack <= ~acked;
                     if (!polling && acked && last != 2'h0 && sent_cmd && sent_code == wscl_pkg::CMD_RESTORE)
                        nv_pend <= 1'b1;
                     else if (!polling && acked && last != 2'h0 && sent_cmd &&
                              sent_code == wscl_pkg::CMD_NO_OPERATION)
                        nv_pend <= 1'b0;
                     if ((polling && !acked) || (!polling && poll_req)) begin
                        polling <= 1'b1;
                        last <= 2'h0;
                        st <= H_START;
                     end else begin
                        polling <= 1'b0;
                        st <= H_IDLE;
                     end
                  end
               end
               H_IDLE: st <= H_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign link.scl = scl;
   assign link.host_sda_oe = sda_oe;
   assign link.host_sda_o = 1'b0; // open drain, only pulls low
endmodule : wscl_host
`default_nettype wire

// ==== design/wscl_link_if.sv ====
`default_nettype none
interface wscl_link_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;

   // wired-and data line with pull-up
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : wscl_link_if
`default_nettype wire

// ==== design/wscl_pkg.sv ====
`default_nettype none
package wscl_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned STORE_TIME_MS = 25;
   localparam int unsigned STORE_CYCLES = STORE_TIME_MS * CLK_MHZ * 1000;
   localparam logic [3:0] SCL_QUARTER = 4'h7; // quarter link period minus one

   // ----------------------------------------------------------------
   // link addressing
   // ----------------------------------------------------------------
   localparam logic [4:0] WIPER_PREFIX = 5'h0B; // arbitrary
   localparam logic [4:0] MEM_PREFIX = 5'h14; // arbitrary

   // ----------------------------------------------------------------
   // instruction byte layout
   // ----------------------------------------------------------------
   localparam int CMD_FLAG_BIT = 7;
   localparam int NV_SEL_BIT = 6;
   localparam int CMD_MSB = 6;
   localparam int CMD_LSB = 3;
   localparam int CH_MSB = 1;
   localparam int ADDR_MSB = 4;

   // ----------------------------------------------------------------
   // shortcut command codes
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_NO_OPERATION = 4'h0;
   localparam logic [3:0] CMD_RESTORE = 4'h1;
   localparam logic [3:0] CMD_STORE = 4'h2;
   localparam logic [3:0] CMD_SHR = 4'h3;
   localparam logic [3:0] CMD_SHR_ALL = 4'h4;
   localparam logic [3:0] CMD_DN = 4'h5;
   localparam logic [3:0] CMD_DN_ALL = 4'h6;
   localparam logic [3:0] CMD_RESET_ALL = 4'h7;
   localparam logic [3:0] CMD_SHL = 4'h8;
   localparam logic [3:0] CMD_SHL_ALL = 4'h9;
   localparam logic [3:0] CMD_UP = 4'hA;
   localparam logic [3:0] CMD_UP_ALL = 4'hB;

   // ----------------------------------------------------------------
   // wiper scales and nonvolatile contents
   // ----------------------------------------------------------------
   localparam logic [8:0] FS9 = 9'h1FF;
   localparam logic [8:0] MID9 = 9'h100;
   localparam logic [8:0] FS7 = 9'h07F;
   localparam logic [8:0] MID7 = 9'h040;
   localparam int NV_BYTES = 16;
   localparam logic [7:0] NV_RESET_VAL [0:15] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h40, 8'h00, 8'h00, 8'h00,
                                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // ----------------------------------------------------------------
   // host register map
   // ----------------------------------------------------------------
   localparam logic [3:0] FRAME_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;
   localparam int FR_DATA_LSB = 8;
   localparam int FR_HAS_DATA_BIT = 16;
   localparam int FR_PINS_LSB = 17;
   localparam int FR_POLL_BIT = 19;
   localparam int ST_ACTIVE_BIT = 0;
   localparam int ST_NACK_BIT = 1;
   localparam int ST_NVREAD_BIT = 2;
endpackage : wscl_pkg
`default_nettype wire

// ==== verif/tb_wiper_shortcut_command_logic.sv ====
`default_nettype none
module tb_wiper_shortcut_command_logic;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned STORE_N = 2000;
   // command steps as {code, channel}
   localparam logic [5:0] SEQ_A [13] = '{6'h20, 6'h28, 6'h0C, 6'h1B, 6'h13, 6'h27, 6'h2F, 6'h2A, 6'h22,
      6'h2A, 6'h15, 6'h30, 6'h03};
   localparam logic [5:0] SEQ_Z [4] = '{6'h15, 6'h21, 6'h0D, 6'h15};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic hw_reset_n = 1'b1;
   logic [1:0] pins = 2'h2;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, st;
   logic avs_waitrequest, busy, nv_read_state;
   logic [8:0] wiper0, wiper1;
   logic [6:0] wiper2;
   logic [8:0] w [3];
   logic [8:0] nv [3];
   int fail_count = 0;
   int samples_checked = 0;
   // clock
   always #2.5 mclk = ~mclk;
   wscl_link_if link_if ();
   wscl_device #(.STORE_CYCLES(STORE_N)) i_wscl_device (.mclk(mclk), .rst_n(rst_n), .link(link_if), .wp(wp),
      .hw_reset_n(hw_reset_n), .slave_address_pin_high(pins[1]), .slave_address_pin_low(pins[0]),
      .memory_address_pin_high(1'b0), .memory_address_pin_low(1'b1), .wiper0(wiper0), .wiper1(wiper1),
      .wiper2(wiper2), .busy(busy), .nv_read_state(nv_read_state));
   wscl_host i_wscl_host (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link_if));
   wscl_assertions #(.STORE_CYCLES(STORE_N)) i_wscl_assertions (.mclk(mclk), .rst_n(rst_n),
      .scl(link_if.scl), .dev_sda_oe(link_if.dev_sda_oe), .avs_read(avs_read),
      .avs_waitrequest(avs_waitrequest), .busy(busy), .wiper0(wiper0), .wiper2(wiper2));
   // compare and count
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_all();
      chk(wiper0, w[0]);
      chk(wiper1, w[1]);
      chk({2'b00, wiper2}, w[2]);
   endtask : chk_all
   // one access, held until waitrequest is seen low
   task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= ~rd;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      st = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge mclk);
   endtask : av
   // send a frame, wait until the link is idle
   task automatic frame(input logic [7:0] ins, input logic has, input logic poll, input logic [1:0] p);
      av(1'b0, wscl_pkg::FRAME_OFFSET, {12'h000, poll, p, has, 8'h00, ins});
      do av(1'b1, wscl_pkg::STATUS_OFFSET, 32'h0000_0000); while (st[wscl_pkg::ST_ACTIVE_BIT] !== 1'b0);
   endtask : frame
   // model of one channel under a command
   function automatic logic [8:0] step(input logic [3:0] c, input int i);
      logic [8:0] fs;
      logic [8:0] v;
      fs = (i == 2) ? 9'h07F : 9'h1FF;
      v = w[i];
      case (c)
         4'h1, 4'h7: v = nv[i];
         4'h3, 4'h4: v = v >> 1;
         4'h5, 4'h6: v = (v == 9'h000) ? v : v - 9'h001;
         4'h8, 4'h9: v = (v == 9'h000) ? 9'h001 : ((v > (fs >> 1)) ? fs : v << 1);
         4'hA, 4'hB: v = (v == fs) ? v : v + 9'h001;
         default: v = v;
      endcase
      return v;
   endfunction : step
   task automatic cmd(input logic [3:0] c, input logic [1:0] ch);
      frame({1'b1, c, 1'b0, ch}, 1'b0, 1'b0, pins);
      if (c == 4'h2 && wp) nv[ch] = w[ch];
      for (int i = 0; i < 3; i++) if (c inside {4'h4, 4'h6, 4'h7, 4'h9, 4'hB} || ch == i) w[i] = step(c, i);
      chk_all();
   endtask : cmd
   task automatic test_done();
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done
   // watchdog
   initial begin
      #400000;
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      test_done();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (8) @(posedge mclk);
      w = '{9'h100, 9'h100, 9'h040};
      nv = w;
      chk_all();
      foreach (SEQ_A[k]) cmd(SEQ_A[k][5:2], SEQ_A[k][1:0]);
      frame(8'h02, 1'b1, 1'b0, pins);
      frame(8'h03, 1'b1, 1'b0, pins);
      w[1] = 9'h000;
      foreach (SEQ_Z[k]) cmd(SEQ_Z[k][5:2], SEQ_Z[k][1:0]);
      frame(8'hD0, 1'b0, 1'b0, ~pins);
      chk({8'h00, st[wscl_pkg::ST_NACK_BIT]}, 9'h001);
      cmd(4'h2, 2'd0);
      chk({8'h00, busy}, 9'h000);
      wp <= 1'b1;
      cmd(4'h2, 2'd0);
      chk({8'h00, busy}, 9'h001);
      frame(8'hA9, 1'b0, 1'b0, pins);
      chk({8'h00, st[wscl_pkg::ST_NACK_BIT]}, 9'h001);
      chk_all();
      frame(8'h83, 1'b0, 1'b1, pins);
      chk({7'h00, busy, st[wscl_pkg::ST_NACK_BIT]}, 9'h000);
      cmd(4'h5, 2'd0);
      cmd(4'h7, 2'd3);
      cmd(4'hA, 2'd1);
      cmd(4'h1, 2'd1);
      chk({7'h00, nv_read_state, st[wscl_pkg::ST_NVREAD_BIT]}, 9'h003);
      cmd(4'h0, 2'd3);
      chk({8'h00, nv_read_state}, 9'h000);
      cmd(4'hB, 2'd3);
      hw_reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      hw_reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      w = nv;
      chk_all();
      test_done();
   end
endmodule : tb_wiper_shortcut_command_logic
`default_nettype wire

// ==== verif/wscl_assertions.sv ====
`default_nettype none
module wscl_assertions #(
   parameter int unsigned STORE_CYCLES = 200
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // link and host bus
   input wire logic scl,
   input wire logic dev_sda_oe,
   input wire logic avs_read,
   input wire logic avs_waitrequest,
   // device state
   input wire logic busy,
   input wire logic [8:0] wiper0,
   input wire logic [6:0] wiper2
);
   // length of the current busy run
   logic [31:0] busy_len;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= 32'h0000_0000;
      end else begin
         busy_len <= busy ? busy_len + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // first cycles of an acknowledge pull
   sequence ack_held;
      dev_sda_oe [*8];
   endsequence
   chk_reset_reload: assert property (!$past(rst_n) |=> wiper0 == 9'h100 && wiper2 == 7'h40)
      else $error("wipers not reloaded");
   chk_store_length: assert property ($fell(busy) |-> busy_len == STORE_CYCLES)
      else $error("store time wrong");
   chk_busy_no_ack: assert property (busy && $past(busy, 40) |-> !dev_sda_oe)
      else $error("ack while storing");
   chk_ack_width: assert property ($rose(dev_sda_oe) |-> ack_held ##[22:26] !dev_sda_oe)
      else $error("ack width wrong");
   chk_ack_scl_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
      else $error("ack moved while clock high");
   chk_scl_high: assert property ($rose(scl) |-> scl [*8])
      else $error("link clock high too short");
   chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read not answered");
endmodule : wscl_assertions
`default_nettype wire
